// file: core/dds_control_word_decode.v
/*
  dds control word decoder: decodes serial words into the control register,
  frequency words a/b and phase offsets a/b, and runs a 28-bit phase
  accumulator from the selected words. assumes the host obeys the link
  framing and that the phase write format (top bits 11, bit 13 picks a/b)
  is acceptable for the phase registers.
*/
`timescale 1ns/10ps
`include "dds_ctrl_defs.vh"
// Function
// [RL1] with full-word mode on, a 28-bit frequency value comes as two words, low 14 bits first.
// [RL2] the host puts the same frequency address on both words of a paired load.
// [RL3] in paired mode the frequency register changes only after both halves arrive.
// [RL4] with full-word mode off, each write changes one 14-bit half and keeps the other.
// [RL5] in split mode half select 1 writes the upper half and 0 the lower half.
// [RL6] half select is ignored while full-word mode is on.
// [RL7] the frequency select bit picks word a or word b as the phase increment.
// [RL8] the phase select bit picks offset a or offset b for the phase adder.
// [RL9] the host writes zero to reserved control bit nine.
// [RL10] while the reset bit is 1 the datapath sits at zero, releasing when it is 0.
// [RL11] while the clock gate bit is 1 the accumulator stops and the output holds.
// [RL12] in paired mode the first half waits in a holding register until the second word.
// [RL13] a word with top bits 00 writes the control register.
// [RL14] words shift in on falling link clock edges while frame sync is low.
// [RL15] a top-bit code of 01 or 10 addresses a frequency register, 01 being word a.
// [RL16] frequency select 0 routes word a and 1 routes word b.
module dds_control_word_decode (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_sclk,
  input wire i_sdata,
  input wire i_frame_sync_low_n,
  output reg [15:0] o_control_word,
  output reg [27:0] o_frequency_word_a,
  output reg [27:0] o_frequency_word_b,
  output reg [11:0] o_phase_offset_a,
  output reg [11:0] o_phase_offset_b,
  output reg [27:0] o_accumulator,
  output reg [11:0] o_phase_out,
  output reg o_datapath_reset,
  output reg o_clock_running
);
  wire word_valid;
  wire [15:0] word;
  wire [1:0] addr;
  wire [13:0] payload;
  wire full_word_two_write;
  wire half_select;
  wire freq_source_choice;
  wire phase_source_choice;
  wire master_clock_gate;
  wire dp_reset;
  reg [13:0] hold_lsb_r;
  reg hold_valid_r;
  reg [1:0] hold_addr_r;
  reg [27:0] freq_sel_nxt;
  reg [11:0] phase_sel_nxt;

  serial_word_rx rx (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_sclk(i_sclk),
    .i_sdata(i_sdata),
    .i_frame_sync_low_n(i_frame_sync_low_n),
    .o_word_valid(word_valid),
    .o_word(word)
  );

  // address and payload split of each received word
  assign addr = word[`ADDR_HI:`ADDR_LO];
  assign payload = word[`HALF_BITS-1:0];
  // control fields as they stand in the register
  assign full_word_two_write = o_control_word[`BIT_FULL_WORD];
  assign half_select = o_control_word[`BIT_HALF_SEL];
  assign freq_source_choice = o_control_word[`BIT_FREQ_SEL];
  assign phase_source_choice = o_control_word[`BIT_PHASE_SEL];
  assign dp_reset = o_control_word[`BIT_DP_RESET];
  assign master_clock_gate = o_control_word[`BIT_CLK_GATE];

  // control register; reserved bit 9 is stored as sent, the host keeps it 0
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_control_word <= `CTRL_RESET_VAL;
    end else if (word_valid && addr == `ADDR_CTRL) begin // [RL13]
      o_control_word <= {2'b00, payload};
    end
  end

  // frequency writes: paired mode holds the low half, split mode writes one half
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_frequency_word_a <= 28'h000_0000;
      o_frequency_word_b <= 28'h000_0000;
      hold_lsb_r <= 14'h0000;
      hold_valid_r <= 1'b0;
      hold_addr_r <= 2'h0;
    end else if (word_valid) begin
      if (addr == `ADDR_CTRL) begin
        // a mode change drops any half-finished pair
        hold_valid_r <= 1'b0;
      end else if (addr == `ADDR_FREQ_A || addr == `ADDR_FREQ_B) begin // [RL15]
        if (full_word_two_write) begin // [RL6]
          if (!hold_valid_r || hold_addr_r != addr) begin
            // first word: low 14 bits parked, register untouched [RL1] [RL12]
            hold_lsb_r <= payload;
            hold_addr_r <= addr;
            hold_valid_r <= 1'b1;
          end else begin
            // second word commits all 28 bits at once [RL3] [RL12]
            hold_valid_r <= 1'b0;
            if (addr == `ADDR_FREQ_A)
              o_frequency_word_a <= {payload, hold_lsb_r};
            else
              o_frequency_word_b <= {payload, hold_lsb_r};
          end
        end else begin
          hold_valid_r <= 1'b0;
          if (addr == `ADDR_FREQ_A) begin
            if (half_select) // [RL5]
              o_frequency_word_a[27:14] <= payload; // [RL4]
            else
              o_frequency_word_a[13:0] <= payload; // [RL4]
          end else begin
            if (half_select) // [RL5]
              o_frequency_word_b[27:14] <= payload; // [RL4]
            else
              o_frequency_word_b[13:0] <= payload; // [RL4]
          end
        end
      end
    end
  end

  // phase offset writes: top bits 11, bit 13 picks offset b
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_phase_offset_a <= 12'h000;
      o_phase_offset_b <= 12'h000;
    end else if (word_valid && addr == `ADDR_PHASE) begin
      if (word[`PHASE_SEL_BIT])
        o_phase_offset_b <= word[`PHASE_BITS-1:0];
      else
        o_phase_offset_a <= word[`PHASE_BITS-1:0];
    end
  end

  // source selection for increment and offset
  always @* begin
    freq_sel_nxt = freq_source_choice ? o_frequency_word_b : o_frequency_word_a; // [RL7] [RL16]
    phase_sel_nxt = phase_source_choice ? o_phase_offset_b : o_phase_offset_a; // [RL8]
  end

  // accumulator; the clock gate is an enable, never a gated clock, to keep one domain
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_accumulator <= 28'h000_0000;
      o_phase_out <= 12'h000;
    end else if (dp_reset) begin // [RL10]
      o_accumulator <= 28'h000_0000;
      o_phase_out <= 12'h000;
    end else if (!master_clock_gate) begin // [RL11]
      o_accumulator <= o_accumulator + freq_sel_nxt;
      o_phase_out <= o_accumulator[27:16] + phase_sel_nxt;
    end
  end

  // status copies of reset and clock gate bits
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_datapath_reset <= 1'b0;
      o_clock_running <= 1'b1;
    end else begin
      o_datapath_reset <= dp_reset; // [RL10]
      o_clock_running <= ~master_clock_gate; // [RL11]
    end
  end
endmodule // dds_control_word_decode

// file: core/dds_ctrl_defs.vh
/*
  constants for the dds control word decoder: word fields, control bit
  positions, register widths. assumes inclusion by the core files only.
*/
`ifndef DDS_CTRL_DEFS_VH
`define DDS_CTRL_DEFS_VH
`define WORD_BITS 16
`define HALF_BITS 14
`define FREQ_BITS 28
`define PHASE_BITS 12
`define ADDR_HI 15
`define ADDR_LO 14
`define ADDR_CTRL 2'h0
`define ADDR_FREQ_A 2'h1
`define ADDR_FREQ_B 2'h2
`define ADDR_PHASE 2'h3
`define PHASE_SEL_BIT 13
`define BIT_FULL_WORD 13
`define BIT_HALF_SEL 12
`define BIT_FREQ_SEL 11
`define BIT_PHASE_SEL 10
`define BIT_RESERVED9 9
`define BIT_DP_RESET 8
`define BIT_CLK_GATE 7
`define CTRL_RESET_VAL 16'h0000
`define FRAME_BIT_COUNT 5'h10
`endif

// file: core/serial_word_rx.v
/*
  serial word receiver: shifts 16-bit words on falling edges of the link
  clock while the frame sync is low. assumes link pins are asynchronous to
  i_core_clk and the link clock is much slower than the core clock.
*/
`timescale 1ns/10ps
`include "dds_ctrl_defs.vh"
module serial_word_rx (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_sclk,
  input wire i_sdata,
  input wire i_frame_sync_low_n,
  output reg o_word_valid,
  output reg [15:0] o_word
);
  reg [2:0] sclk_s_r;
  reg [1:0] fs_s_r;
  reg [1:0] sd_s_r;
  reg [15:0] shift_r;
  reg [4:0] count_r;
  wire fall;
  wire in_frame;
  // sclk keeps a third stage so the edge detector never reads stage one
  assign fall = sclk_s_r[2] & ~sclk_s_r[1];
  assign in_frame = ~fs_s_r[1];
  // two-flop synchronisers on frame sync and data, three flops on sclk
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sclk_s_r <= 3'h0;
      fs_s_r <= 2'h3;
      sd_s_r <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], i_sclk};
      fs_s_r <= {fs_s_r[0], i_frame_sync_low_n};
      sd_s_r <= {sd_s_r[0], i_sdata};
    end
  end
  // msb first shift; frame release aborts a partial word
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      shift_r <= 16'h0000;
      count_r <= 5'h00;
      o_word_valid <= 1'b0;
      o_word <= 16'h0000;
    end else begin
      o_word_valid <= 1'b0;
      if (!in_frame) begin
        count_r <= 5'h00;
      end else if (fall) begin // [RL14]
        shift_r <= {shift_r[14:0], sd_s_r[1]};
        if (count_r == `FRAME_BIT_COUNT - 5'h01) begin
          count_r <= 5'h00; // back-to-back words in one frame
          o_word_valid <= 1'b1;
          o_word <= {shift_r[14:0], sd_s_r[1]};
        end else begin
          count_r <= count_r + 5'h01;
        end
      end
    end
  end
endmodule // serial_word_rx

// file: tb/dds_ctrl_sva.sv
/* checker for the dds control word decoder ports.
   assumes one core clock domain, synchronous active-low reset. */
`timescale 1ns/10ps
module dds_ctrl_sva (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire [15:0] o_control_word,
  input wire [27:0] o_frequency_word_a,
  input wire [27:0] o_frequency_word_b,
  input wire [11:0] o_phase_offset_a,
  input wire [11:0] o_phase_offset_b,
  input wire [27:0] o_accumulator,
  input wire [11:0] o_phase_out,
  input wire o_datapath_reset,
  input wire o_clock_running
);
  // selected increment and offset, short names keep properties on one line
  wire [15:0] c = o_control_word;
  wire [27:0] a = o_frequency_word_a;
  wire [27:0] f = c[11] ? o_frequency_word_b : a;
  wire [11:0] p = c[10] ? o_phase_offset_b : o_phase_offset_a;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  ctrl_top_a: assert property (c[15:14] == 2'h0)
    else $error("control top bits set");
  dp_reset_a: assert property (o_datapath_reset == $past(c[8]))
    else $error("datapath reset not following bit 8");
  clk_run_a: assert property (o_clock_running == !$past(c[7]))
    else $error("clock running not following bit 7");
  acc_zero_a: assert property (c[8] && $past(c[8]) |-> o_accumulator == 28'h000_0000)
    else $error("accumulator not held at zero");
  acc_hold_a: assert property (c[7] && $past(c[7]) |-> $stable(o_accumulator))
    else $error("accumulator moved while gated");
  // two quiet cycles so a fresh word never races the step check
  acc_step_a: assert property (($stable(c) && $stable(f) && !c[8] && !c[7]) [*2]
    |-> o_accumulator == $past(o_accumulator) + f)
    else $error("accumulator step wrong");
  // the clock gate freezes the phase output too, so only running cycles are summed
  phase_sum_a: assert property (!o_datapath_reset && o_clock_running
    |-> o_phase_out == $past(o_accumulator[27:16] + p))
    else $error("phase output sum wrong");
  split_half_a: assert property (!c[13] && !$past(c[13])
    |-> $stable(a[27:14]) || $stable(a[13:0]))
    else $error("both halves changed in split mode");
endmodule // dds_ctrl_sva
bind dds_control_word_decode dds_ctrl_sva dds_ctrl_sva_inst (.*);

// file: tb/host_link_model.sv
/* host side of the three-wire link: frames one 16-bit word at a time.
   assumes calls start just after a core clock falling edge. */
`timescale 1ns/10ps
module host_link_model (
  output logic o_sclk,
  output logic o_sdata,
  output logic o_frame_sync_low_n
);
  // link idles high and still; data line is not kept between frames
  initial begin
    o_sclk = 1'b1;
    o_sdata = 1'b0;
    o_frame_sync_low_n = 1'b1;
  end
  // msb first, bit set while sclk high, taken on its fall
  task automatic send(input logic [15:0] w);
    o_frame_sync_low_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_sdata = w[i];
      #80 o_sclk = 1'b0;
      #80 o_sclk = 1'b1;
    end
    #80 o_frame_sync_low_n = 1'b1;
    o_sdata = ~o_sdata; // released line shows no stale bit
  endtask
endmodule // host_link_model

// file: tb/testbench.sv
/* self-checking bench for the dds control word decoder.
   assumes the host model and the bound checker are compiled first. */
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, sdata, fs_n, dpr, run;
  logic [15:0] cw;
  logic [27:0] fa, fb, acc, acc0, accp;
  logic [11:0] pa, pb, po, pe;
  int n_errors = 0;
  int n_checks = 0;
  // 100 MHz core clock
  initial begin
    forever #5 clk = ~clk;
  end
  host_link_model host_link_model_inst (.o_sclk(sclk), .o_sdata(sdata),
    .o_frame_sync_low_n(fs_n));
  dds_control_word_decode dds_control_word_decode_inst (.i_core_clk(clk),
    .i_reset_n(rst_n), .i_sclk(sclk), .i_sdata(sdata), .i_frame_sync_low_n(fs_n),
    .o_control_word(cw), .o_frequency_word_a(fa), .o_frequency_word_b(fb),
    .o_phase_offset_a(pa), .o_phase_offset_b(pb), .o_accumulator(acc),
    .o_phase_out(po), .o_datapath_reset(dpr), .o_clock_running(run));
  task automatic chk(input logic [27:0] s, input logic [27:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one word, then room for sync and decode latency
  task automatic wr(input logic [15:0] w);
    host_link_model_inst.send(w);
    repeat (10) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang past about six and a half times the expected run ends it as a failure
  initial begin
    #200000;
    n_errors++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk(run, 1'b1);
    wr(16'h3100); // paired loads, half select set, datapath held
    chk(cw, 16'h3100);
    chk(dpr, 1'b1);
    chk(acc, 28'h000_0000);
    wr(16'h4000 | 16'h1234);
    chk(fa, 28'h000_0000);
    wr(16'h4000 | 16'h2abc);
    chk(fa, {14'h2abc, 14'h1234});
    $display("paired load test done");
    wr(16'h0100); // split mode, low half
    wr(16'h8000 | 16'h0155);
    chk(fb, 28'h000_0155);
    wr(16'h1100); // split mode, high half
    wr(16'h8000 | 16'h3aaa);
    chk(fb, {14'h3aaa, 14'h0155});
    wr(16'hc000 | 16'h0123);
    wr(16'he000 | 16'h0456);
    chk(pa, 12'h123);
    chk(pb, 12'h456);
    $display("split load test done");
    wr(16'h0800); // word b drives, datapath released
    chk(dpr, 1'b0);
    acc0 = acc;
    @(negedge clk);
    chk(acc - acc0, {14'h3aaa, 14'h0155});
    wr(16'h0480); // gate clock, offset b
    chk(run, 1'b0);
    acc0 = acc;
    repeat (5) @(negedge clk);
    chk(acc, acc0);
    // last running cycle summed the step before acc0 with offset a
    accp = acc0 - {14'h3aaa, 14'h0155};
    pe = accp[27:16] + 12'h123;
    chk({16'h0000, po}, {16'h0000, pe});
    $display("datapath test done");
    tally_and_finish;
  end
endmodule // testbench
